// [hdl/mcs_host_port.sv]
// Serial host port: four-wire slave exchanging fixed 32-bit frames.
// Assumes read data and status are supplied by the controller core on
// clk_sys; host pins are asynchronous and are synchronised here.
// Pin levels land about four cycles late through the filter; the host
// timing minimums are what keep edges and data bits in order.
// Frames of other than 32 bits raise frame_error and commit nothing.
`timescale 1ns/1ps
`default_nettype none
module mcs_host_port
   import mcs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic host_select_n,
   input wire logic host_sclk,
   input wire logic host_sdi,
   output logic shared_out_irq_pin,
   input wire logic irq_status_low,
   input wire logic [DATA_W-1:0] rd_data,
   input wire logic [STAT_W-1:0] status_bits,
   output logic por_busy,
   output logic frame_valid,
   output logic [FRAME_W-1:0] frame_data,
   output logic frame_ram_sel,
   output logic [ADDR_W-1:0] frame_addr,
   output logic frame_read,
   output logic [DATA_W-1:0] frame_wdata,
   output logic wr_strobe,
   output logic rd_strobe,
   output logic frame_error,
   output logic [PRESC_W-1:0] step_clock_prescaler
);

   // ------------------------------------------------------------
   // Reset and pin conditioning
   // ------------------------------------------------------------
   logic rst;
   mcs_pins_if pins ();

   mcs_por u_por (
      .clk_sys(clk_sys),
      .srst(srst),
      .por_active(rst)
   );

   mcs_pin_sync u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_raw({host_sdi, host_sclk, host_select_n}),
      .pins(pins)
   );

   assign por_busy = rst;

   // ------------------------------------------------------------
   // Edge detection on cleaned levels
   // ------------------------------------------------------------
   logic sel_d_r, sclk_d_r;
   logic sel_d_nxt, sclk_d_nxt;
   logic sel_fall, sel_rise, sclk_rise, sclk_fall;

   always_comb begin
      sel_d_nxt = pins.sel_n;
      sclk_d_nxt = pins.sclk;
   end

   // Idle level high, so reset leaves no false edge behind
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sel_d_r <= 1'b1;
         sclk_d_r <= 1'b1;
      end else begin
         sel_d_r <= sel_d_nxt;
         sclk_d_r <= sclk_d_nxt;
      end
   end

   assign sel_fall = sel_d_r && !pins.sel_n;
   assign sel_rise = !sel_d_r && pins.sel_n;
   // Select edges stay ungated; the sequencer decides what a rise means
   // clock edges gated by select
   assign sclk_rise = !sclk_d_r && pins.sclk && !pins.sel_n;
   assign sclk_fall = sclk_d_r && !pins.sclk && !pins.sel_n;

   // ------------------------------------------------------------
   // Frame sequencer, receive and transmit shifters
   // ------------------------------------------------------------
   mcs_state_t state_r, state_nxt;
   logic [FRAME_W-1:0] rx_r, rx_nxt;
   logic [FRAME_W-1:0] tx_r, tx_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic ovf_r, ovf_nxt;

   always_comb begin
      state_nxt = state_r;
      rx_nxt = rx_r;
      tx_nxt = tx_r;
      cnt_nxt = cnt_r;
      ovf_nxt = ovf_r;
      case (state_r)
         ST_IDLE: begin
            if (sel_fall) begin
               // Word answers the previous request; core has it ready
               // status high, data low
               tx_nxt = {status_bits, rd_data};
               cnt_nxt = CNT_ZERO;
               ovf_nxt = 1'b0;
               state_nxt = ST_FRAME;
            end
         end
         ST_FRAME: begin
            if (sel_rise) begin
               state_nxt = ST_COMMIT;
            end else begin
               if (sclk_rise) begin
                  rx_nxt = {rx_r[FRAME_W-2:0], pins.sdi};
                  // Extra edges mark the frame too long, never wrap
                  if (cnt_r == FRAME_BITS) begin
                     ovf_nxt = 1'b1;
                  end else begin
                     cnt_nxt = cnt_r + CNT_ONE;
                  end
               end
               // First fall precedes bit 31; shifting then would lose it
               if (sclk_fall && (cnt_r != CNT_ZERO)) begin
                  tx_nxt = {tx_r[FRAME_W-2:0], 1'b0};
               end
            end
         end
         ST_COMMIT: begin
            // One cycle for buffer and strobes to take the word
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_r <= ST_IDLE;
         rx_r <= FRAME_RST;
         tx_r <= FRAME_RST;
         cnt_r <= CNT_ZERO;
         ovf_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         rx_r <= rx_nxt;
         tx_r <= tx_nxt;
         cnt_r <= cnt_nxt;
         ovf_r <= ovf_nxt;
      end
   end

   // ------------------------------------------------------------
   // Holding buffer and decode
   // ------------------------------------------------------------
   logic [FRAME_W-1:0] buf_r, buf_nxt;
   logic val_r, val_nxt;
   logic err_r, err_nxt;
   logic wr_r, wr_nxt;
   logic rd_r, rd_nxt;
   logic count_ok;
   logic good_frame;

   // Short or long frames are dropped so a partial write never lands
   assign count_ok = (cnt_r == FRAME_BITS) && !ovf_r;
   assign good_frame = (state_r == ST_COMMIT) && count_ok;

   always_comb begin
      buf_nxt = buf_r;
      val_nxt = 1'b0;
      err_nxt = 1'b0;
      wr_nxt = 1'b0;
      rd_nxt = 1'b0;
      if (good_frame) begin
         buf_nxt = rx_r;
         val_nxt = 1'b1;
         if (rx_r[RW_BIT] == ACC_READ) begin
            rd_nxt = 1'b1;
         end else begin
            wr_nxt = 1'b1;
         end
      end else if (state_r == ST_COMMIT) begin
         err_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         buf_r <= FRAME_RST;
         val_r <= 1'b0;
         err_r <= 1'b0;
         wr_r <= 1'b0;
         rd_r <= 1'b0;
      end else begin
         buf_r <= buf_nxt;
         val_r <= val_nxt;
         err_r <= err_nxt;
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
      end
   end

   assign frame_valid = val_r;
   assign frame_error = err_r;
   assign wr_strobe = wr_r;
   assign rd_strobe = rd_r;

   // ------------------------------------------------------------
   // Field decode of the holding buffer
   // ------------------------------------------------------------
   assign frame_data = buf_r;
   assign frame_ram_sel = buf_r[RRS_BIT];
   assign frame_addr = buf_r[ADDR_HI:ADDR_LO];
   assign frame_read = buf_r[RW_BIT];
   assign frame_wdata = buf_r[DATA_W-1:0];

   // ------------------------------------------------------------
   // Step clock prescaler
   // ------------------------------------------------------------
   logic [PRESC_W-1:0] presc_r, presc_nxt;

   always_comb begin
      presc_nxt = presc_r;
      // Register writes to its address only; RAM writes pass by
      if (wr_r && (buf_r[RRS_BIT] == SEL_REG)
          && (buf_r[ADDR_HI:ADDR_LO] == PRESC_ADDR)) begin
         presc_nxt = buf_r[PRESC_W-1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         presc_r <= PRESC_RST;
      end else begin
         presc_r <= presc_nxt;
      end
   end

   assign step_clock_prescaler = presc_r;

   // ------------------------------------------------------------
   // Shared output pin
   // ------------------------------------------------------------
   // Registered so data changes one cycle after the shift, keeping the
   // output bit behind the four-cycle floor after the clock falls
   logic pin_r, pin_nxt;

   always_comb begin
      if (pins.sel_n) begin
         pin_nxt = irq_status_low;
      end else if (state_r == ST_FRAME) begin
         pin_nxt = tx_r[FRAME_W-1];
      end else begin
         // Hold until the new word is loaded, never a stale bit
         pin_nxt = pin_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         // High reads as no interrupt pending
         pin_r <= 1'b1;
      end else begin
         pin_r <= pin_nxt;
      end
   end

   assign shared_out_irq_pin = pin_r;

endmodule
`default_nettype wire

// [shared/mcs_pkg.sv]
// Constants and types for the motion controller serial host port.
// Assumes a single system clock; timing counts are in system clock cycles, frame counts in bits.
package mcs_pkg;

   // ------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------
   localparam int FRAME_W = 32;
   localparam int DATA_W = 24;
   localparam int STAT_W = 8;
   localparam int ADDR_W = 6;
   localparam int CNT_W = 6;
   localparam int RRS_BIT = 31;
   localparam int ADDR_HI = 30;
   localparam int ADDR_LO = 25;
   localparam int RW_BIT = 24;
   localparam logic [CNT_W-1:0] FRAME_BITS = 6'h20;
   localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

   // ------------------------------------------------------------
   // Access type and reset values
   // ------------------------------------------------------------
   localparam logic ACC_READ = 1'b1;
   localparam logic ACC_WRITE = 1'b0;
   localparam logic SEL_REG = 1'b0;
   localparam int PRESC_W = 4;
   localparam logic [PRESC_W-1:0] PRESC_RST = 4'hf;
   localparam logic [ADDR_W-1:0] PRESC_ADDR = 6'h3e;
   localparam logic [FRAME_W-1:0] FRAME_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] DATA_RST = 24'h00_0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 6'h00;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int POR_W = 5;
   localparam logic [POR_W-1:0] POR_CYC = 5'h10;
   localparam logic [POR_W-1:0] POR_ZERO = 5'h00;
   localparam logic [POR_W-1:0] POR_ONE = 5'h01;
   localparam int SYNC_N = 3;

   typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_COMMIT} mcs_state_t;

endpackage

// [shared/mcs_pins_if.sv]
// Cleaned host pin levels passed from the pin synchroniser to the port.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface mcs_pins_if;
   logic sel_n;
   logic sclk;
   logic sdi;
   modport sync (output sel_n, output sclk, output sdi);
   modport port (input sel_n, input sclk, input sdi);
endinterface
`default_nettype wire

// [hdl/mcs_pin_sync.sv]
// Three-stage synchroniser for the host select, clock and data pins.
// Assumes the pins are asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module mcs_pin_sync
   import mcs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [2:0] pin_raw,
   mcs_pins_if.sync pins
);
   logic [2:0] s1_r, s2_r, s3_r, cln_r;
   logic [2:0] s1_nxt, s2_nxt, s3_nxt, cln_nxt;

   // ------------------------------------------------------------
   // Agreement filter
   // ------------------------------------------------------------
   // Idle level high on all lines; no spurious edge after reset
   always_comb begin
      s1_nxt = pin_raw;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      cln_nxt = cln_r;
      for (int i = 0; i < 3; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            cln_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s1_r <= 3'h7;
         s2_r <= 3'h7;
         s3_r <= 3'h7;
         cln_r <= 3'h7;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         cln_r <= cln_nxt;
      end
   end

   assign pins.sel_n = cln_r[0];
   assign pins.sclk = cln_r[1];
   assign pins.sdi = cln_r[2];
endmodule
`default_nettype wire

// [hdl/mcs_por.sv]
// Internal power-on reset stretcher.
// Assumes srst comes from the supply monitor, not from a user pin.
`timescale 1ns/1ps
`default_nettype none
module mcs_por
   import mcs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   output logic por_active
);
   logic [POR_W-1:0] cnt_r, cnt_nxt;

   // ------------------------------------------------------------
   // Hold-off counter
   // ------------------------------------------------------------
   // Keeps logic in reset a while so the clock can settle
   always_comb begin
      cnt_nxt = cnt_r;
      if (cnt_r != POR_ZERO) begin
         cnt_nxt = cnt_r - POR_ONE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cnt_r <= POR_CYC;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign por_active = srst || (cnt_r != POR_ZERO);
endmodule
`default_nettype wire

// [bench/mcs_host_model.sv]
// Host master model driving the four-wire serial port.
// Assumes the bench calls its tasks; pins change on falling clk_sys.
`timescale 1ns/1ps
`default_nettype none
module mcs_host_model (
   input wire logic clk_sys,
   input wire logic shared_out_irq_pin,
   output logic host_select_n,
   output logic host_sclk,
   output logic host_sdi
);
   // ------------------------------------------------------------
   // Idle levels
   // ------------------------------------------------------------
   initial begin
      host_select_n = 1'b1;
      host_sclk = 1'b1;
      host_sdi = 1'b0;
   end

   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // ------------------------------------------------------------
   // One frame of n bits
   // ------------------------------------------------------------
   task automatic xfer(input logic [31:0] w, input int n,
                       output logic [31:0] r);
      r = 32'h0;
      host_select_n = 1'b0;
      wait_n(6);
      for (int i = 31; i > 31 - n; i--) begin
         host_sclk = 1'b0;
         // Bits past the 32nd carry zero
         host_sdi = (i >= 0) ? w[i] : 1'b0;
         // Low and high well over three cycles
         wait_n(7);
         if (i >= 0) r[i] = shared_out_irq_pin;
         host_sclk = 1'b1;
         wait_n(5);
      end
      host_select_n = 1'b1;
      // Released data line must not keep its last value
      host_sdi = ~host_sdi;
      wait_n(8);
   endtask

   // Clock pulses with select high, which must be ignored
   task automatic idle_clocks(input int n);
      repeat (n) begin
         host_sclk = 1'b0;
         wait_n(4);
         host_sclk = 1'b1;
         wait_n(4);
      end
   endtask
endmodule
`default_nettype wire

// [bench/mcs_host_port_asserts.sv]
// Concurrent checks on the serial host port.
// Assumes binding onto mcs_host_port; single clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module mcs_host_port_asserts
   import mcs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic host_select_n,
   input wire logic host_sclk,
   input wire logic irq_status_low,
   input wire logic shared_out_irq_pin,
   input wire logic por_busy,
   input wire logic frame_valid,
   input wire logic [FRAME_W-1:0] frame_data,
   input wire logic frame_ram_sel,
   input wire logic [ADDR_W-1:0] frame_addr,
   input wire logic frame_read,
   input wire logic [DATA_W-1:0] frame_wdata,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   input wire logic frame_error,
   input wire logic [PRESC_W-1:0] step_clock_prescaler
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);

   // ------------------------------------------------------------
   // Reset and framing
   // ------------------------------------------------------------
   a_reset_pin_high: assert property (por_busy && $past(por_busy) |->
      shared_out_irq_pin) else $error("pin not high in reset");
   a_reset_values: assert property (por_busy && $past(por_busy) |->
      step_clock_prescaler == PRESC_RST && frame_data == FRAME_RST)
      else $error("reset values wrong");
   a_strobe_kind: assert property (frame_valid |->
      rd_strobe == frame_read && wr_strobe == !frame_read)
      else $error("strobe does not match access bit");
   a_strobe_needs_valid: assert property ((wr_strobe || rd_strobe) |->
      frame_valid) else $error("strobe without frame");
   a_field_split: assert property (frame_ram_sel == frame_data[RRS_BIT] &&
      frame_addr == frame_data[ADDR_HI:ADDR_LO] &&
      frame_wdata == frame_data[DATA_W-1:0]) else $error("field split");
   a_commit_after_rise: assert property (frame_valid |->
      $past(host_select_n, 4) && !$past(host_select_n, 12))
      else $error("commit without select rise");
   a_buffer_holds: assert property ($changed(frame_data) |->
      frame_valid) else $error("buffer changed outside commit");
   a_presc_write: assert property (wr_strobe && frame_addr == PRESC_ADDR &&
      frame_ram_sel == SEL_REG |=> step_clock_prescaler ==
      $past(frame_wdata[PRESC_W-1:0])) else $error("prescaler write");
   a_presc_hold: assert property ($changed(step_clock_prescaler) |->
      $past(wr_strobe)) else $error("prescaler changed alone");
   a_irq_follow: assert property ((host_select_n && !por_busy)[*8] |->
      shared_out_irq_pin == $past(irq_status_low))
      else $error("idle pin not interrupt");
   a_bit_hold: assert property ($fell(host_sclk) && !host_select_n |=>
      $stable(shared_out_irq_pin)[*3]) else $error("output bit too early");
endmodule

bind mcs_host_port mcs_host_port_asserts i_chk (
   .clk_sys(clk_sys), .srst(srst), .host_select_n(host_select_n),
   .host_sclk(host_sclk), .irq_status_low(irq_status_low),
   .shared_out_irq_pin(shared_out_irq_pin), .por_busy(por_busy),
   .frame_valid(frame_valid), .frame_data(frame_data),
   .frame_ram_sel(frame_ram_sel), .frame_addr(frame_addr),
   .frame_read(frame_read), .frame_wdata(frame_wdata),
   .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
   .frame_error(frame_error), .step_clock_prescaler(step_clock_prescaler)
);
`default_nettype wire

// [bench/test_motion_ctrl_serial_host_port.sv]
// Self-checking bench for the serial host port.
// Assumes mcs_host_model drives the host pins; inputs move on falling clk.
`timescale 1ns/1ps
`default_nettype none
module test_motion_ctrl_serial_host_port
   import mcs_pkg::*;
;
   logic clk_sys, srst, irq_status_low, host_select_n, host_sclk, host_sdi;
   logic shared_out_irq_pin, por_busy, frame_valid, frame_ram_sel;
   logic frame_read, wr_strobe, rd_strobe, frame_error;
   logic [DATA_W-1:0] rd_data, frame_wdata;
   logic [STAT_W-1:0] status_bits;
   logic [FRAME_W-1:0] frame_data;
   logic [ADDR_W-1:0] frame_addr;
   logic [PRESC_W-1:0] step_clock_prescaler;
   int mismatches = 0;
   int n_tests = 0;
   int n_valid = 0;
   int n_wr = 0;
   int n_rd = 0;
   int n_err = 0;

   mcs_host_port i_dut (.clk_sys(clk_sys), .srst(srst),
      .host_select_n(host_select_n), .host_sclk(host_sclk),
      .host_sdi(host_sdi), .shared_out_irq_pin(shared_out_irq_pin),
      .irq_status_low(irq_status_low), .rd_data(rd_data),
      .status_bits(status_bits), .por_busy(por_busy),
      .frame_valid(frame_valid), .frame_data(frame_data),
      .frame_ram_sel(frame_ram_sel), .frame_addr(frame_addr),
      .frame_read(frame_read), .frame_wdata(frame_wdata),
      .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
      .frame_error(frame_error),
      .step_clock_prescaler(step_clock_prescaler));

   mcs_host_model i_host (.clk_sys(clk_sys),
      .shared_out_irq_pin(shared_out_irq_pin),
      .host_select_n(host_select_n), .host_sclk(host_sclk),
      .host_sdi(host_sdi));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // Pulses are one cycle wide, so count them as they pass
   always @(negedge clk_sys) begin
      if (frame_valid === 1'b1) n_valid++;
      if (wr_strobe === 1'b1) n_wr++;
      if (rd_strobe === 1'b1) n_rd++;
      if (frame_error === 1'b1) n_err++;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic frame(input logic [31:0] w, input int n,
                        output logic [31:0] r);
      int base;
      base = n_valid + n_err;
      i_host.xfer(w, n, r);
      for (int k = 0; k < 20 && n_valid + n_err == base; k++)
         @(negedge clk_sys);
      if (n_valid + n_err == base) begin
         mismatches++;
         summarize();
      end
      repeat (2) @(negedge clk_sys);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      srst = 1'b1;
      repeat (12) @(negedge clk_sys);
      srst = 1'b0;
      @(negedge clk_sys);
      chk("por_busy", 32'h1, por_busy);
      chk("pin", 32'h1, shared_out_irq_pin);
      chk("prescaler", 32'hf, step_clock_prescaler);
      chk("frame_data", 32'h0, frame_data);
      // No frame before internal reset ends
      for (int k = 0; k < 40 && por_busy !== 1'b0; k++)
         @(negedge clk_sys);
      chk("por_done", 32'h0, por_busy);
      repeat (4) @(negedge clk_sys);
   endtask

   task automatic t_write();
      logic [31:0] w, r;
      int wr0;
      wr0 = n_wr;
      rd_data = 24'h5a_c3a5;
      status_bits = 8'h96;
      w = {SEL_REG, PRESC_ADDR, ACC_WRITE, 24'h00_000a};
      frame(w, 32, r);
      chk("rx_word", {8'h96, 24'h5a_c3a5}, r);
      chk("frame_data", w, frame_data);
      chk("wr_count", wr0 + 1, n_wr);
      chk("frame_wdata", 32'ha, frame_wdata);
      chk("prescaler", 32'ha, step_clock_prescaler);
   endtask

   task automatic t_ram_write();
      logic [31:0] w, r;
      int wr0;
      wr0 = n_wr;
      w = {1'b1, PRESC_ADDR, ACC_WRITE, 24'h00_0003};
      frame(w, 32, r);
      chk("rx_word", 32'h0112_3456, r);
      chk("wr_count", wr0 + 1, n_wr);
      chk("frame_wdata", 32'h3, frame_wdata);
      chk("frame_addr", 32'h3e, frame_addr);
      chk("prescaler", 32'ha, step_clock_prescaler);
   endtask

   task automatic t_read();
      logic [31:0] w, r;
      int rd0;
      rd0 = n_rd;
      rd_data = 24'h12_3456;
      status_bits = 8'h01;
      w = {1'b1, 6'h15, ACC_READ, 24'h00_0000};
      frame(w, 32, r);
      chk("rx_word", 32'h0112_3456, r);
      chk("rd_count", rd0 + 1, n_rd);
      chk("ram_sel", 32'h1, frame_ram_sel);
      chk("frame_addr", 32'h15, frame_addr);
      chk("frame_read", 32'h1, frame_read);
      chk("prescaler", 32'ha, step_clock_prescaler);
   endtask

   task automatic t_short();
      logic [31:0] r, keep;
      int v0, e0;
      keep = frame_data;
      v0 = n_valid;
      e0 = n_err;
      frame(32'hffff_ffff, 31, r);
      chk("err_count", e0 + 1, n_err);
      frame(32'h0000_0000, 33, r);
      chk("err_long", e0 + 2, n_err);
      chk("valid_count", v0, n_valid);
      chk("frame_data", keep, frame_data);
   endtask

   task automatic t_idle();
      logic [31:0] keep;
      int v0;
      keep = frame_data;
      v0 = n_valid + n_err;
      irq_status_low = 1'b0;
      i_host.idle_clocks(4);
      chk("pin_irq", 32'h0, shared_out_irq_pin);
      chk("frame_data", keep, frame_data);
      chk("events", v0, n_valid + n_err);
      irq_status_low = 1'b1;
      repeat (8) @(negedge clk_sys);
      chk("pin_idle", 32'h1, shared_out_irq_pin);
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      srst = 1'b1;
      irq_status_low = 1'b1;
      rd_data = 24'h00_0000;
      status_bits = 8'h00;
      t_reset();
      t_write();
      t_read();
      t_ram_write();
      t_short();
      t_idle();
      t_reset();
      summarize();
   end

   initial begin
      #2500000;
      mismatches++;
      summarize();
   end
endmodule
`default_nettype wire
